// *** rps_regs.svh ***
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
// Summary of operation
// [RULE_01] The packet length is read as a high byte and a low byte, full length = high*256 + low.
// [RULE_02] The first quality byte holds carrier sense in bit 7 and the 7-bit quality value below.
// [RULE_03] The gain byte holds the 4-bit gain control word in bits 3:0, upper nibble reads zero.
// [RULE_04] An 8-bit signal strength level captured for the received packet is readable.
// [RULE_05] Three checksum bytes are readable, byte 2 at the lowest address, byte 0 at the highest.
// [RULE_06] Four control bytes are readable, control byte 0 lowest and control byte 3 highest.
// [RULE_07] The source address byte of the received packet is readable.
// [RULE_08] The destination address byte of the received packet is readable.
// [RULE_09] The 128-bit cipher result is sixteen bytes, byte 15 lowest and byte 0 highest address.
// [RULE_10] The first calibrator byte holds the 4-bit oscillator word a in bits 7:4.
// [RULE_11] The 5-bit oscillator word b is split: bits 4:1 in the low nibble, bit 0 in the next bit 7.
// [RULE_12] The second calibrator byte holds the 7-bit synthesiser calibration word in bits 6:0.
// [RULE_13] The transmit queue fill count reads as 0 to 96 in bits 6:0, bit 7 zero.
// [RULE_14] The receive queue fill count reads as 0 to 96 in bits 6:0, bit 7 zero.
// [RULE_15] The 32-bit event status spans four bytes, bits 31:24 at the lowest address.
// [RULE_16] Reading an event status byte returns the pending events and clears them.
// [RULE_17] A 32-bit writable mask, reset to zero, selects which events reach the output pin.

// ==========================================================
// Register offsets
`define RPS_MASK_BYTE3        8'h90
`define RPS_MASK_BYTE2        8'h91
`define RPS_MASK_BYTE1        8'h92
`define RPS_MASK_BYTE0        8'h93
`define RPS_LQ_SENSE_SIGNAL   8'hc6
`define RPS_LQ_GAIN           8'hc7
`define RPS_RX_STRENGTH       8'hc8
`define RPS_RX_LEN_HIGH       8'hc9
`define RPS_RX_LEN_LOW        8'hca
`define RPS_RX_CKSUM_BYTE2    8'hcb
`define RPS_RX_CKSUM_BYTE1    8'hcc
`define RPS_RX_CKSUM_BYTE0    8'hcd
`define RPS_RX_CTRL_BYTE0     8'hce
`define RPS_RX_CTRL_BYTE1     8'hcf
`define RPS_RX_CTRL_BYTE2     8'hd0
`define RPS_RX_CTRL_BYTE3     8'hd1
`define RPS_RX_SRC_ADDR       8'hd2
`define RPS_RX_DST_ADDR       8'hd3
`define RPS_CIPHER_FIRST      8'hd4
`define RPS_CIPHER_LAST       8'he3
`define RPS_CAL_HIGH          8'he4
`define RPS_CAL_LOW           8'he5
`define RPS_TX_QUEUE_FILL     8'he6
`define RPS_RX_QUEUE_FILL     8'he7
`define RPS_PART_ID           8'hf0
`define RPS_SILICON_REV       8'hf1
`define RPS_EVENT_BYTE3       8'hfa
`define RPS_EVENT_BYTE2       8'hfb
`define RPS_EVENT_BYTE1       8'hfc
`define RPS_EVENT_BYTE0       8'hfd

// ==========================================================
// Field positions and reset values
`define RPS_SENSE_BIT         7
`define RPS_WORD_A_LSB        4
`define RPS_WORD_B_BIT0_POS   7
`define RPS_LEN_HIGH_LSB      8
`define RPS_BYTE_RESET        8'h00
`define RPS_MASK_RESET        32'h0000_0000
`define RPS_QUEUE_MAX         7'h60
`endif

// *** rps_pkg.sv ***
package rps_pkg;

  typedef logic [7:0] rps_byte_t;

  // State of the status bank, apart from the pending event bytes held in the event instances
  typedef struct packed {
    logic         carrier_sense;
    logic [6:0]   signal_quality_value;
    logic [3:0]   gain_control_word;
    logic [7:0]   signal_strength_level;
    logic [15:0]  received_length;
    logic [23:0]  checksum;
    logic [31:0]  control;
    logic [7:0]   source_address_byte;
    logic [7:0]   destination_address_byte;
    logic [127:0] cipher_result;
    logic [3:0]   oscillator_cal_word_a;
    logic [4:0]   oscillator_cal_word_b;
    logic [6:0]   synth_cal_word;
    logic [6:0]   tx_queue_count;
    logic [6:0]   rx_queue_count;
    logic [31:0]  event_mask;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         irq;
  } rps_state_s;

  // State of one event status byte
  typedef struct packed {
    logic [7:0] pending;
  } rps_event_s;

endpackage : rps_pkg

// *** rps_event_byte.sv ***
`timescale 1ns/10ps
`include "rps_regs.svh"

module rps_event_byte (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire rps_pkg::rps_byte_t set_bits,
  input  wire logic             read_clear,
  output rps_pkg::rps_byte_t    pending
);
  import rps_pkg::*;

  rps_event_s st_q;
  rps_event_s st_d;

  // ==========================================================
  // Sticky events, cleared by a read; an event in the read cycle survives
  always_comb begin
    st_d = st_q;
    if (read_clear) begin
      st_d.pending = set_bits;                     // see [RULE_16]
    end else begin
      st_d.pending = st_q.pending | set_bits;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{pending: `RPS_BYTE_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign pending = st_q.pending;

endmodule : rps_event_byte

// *** rps_status_bank.sv ***
`timescale 1ns/10ps
`include "rps_regs.svh"

module rps_status_bank #(
  parameter logic [7:0] PART_ID_VALUE = 8'h5a,  // Arbitrary value
  parameter logic [7:0] REVISION_VALUE = 8'h12  // Arbitrary value
) (
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // Register access port
  input  wire logic [7:0]     reg_addr,
  input  wire logic           reg_rd,
  input  wire logic           reg_wr,
  input  wire logic [7:0]     reg_wdata,
  output logic [7:0]          reg_rdata,
  output logic                reg_rvalid,
  // Received packet information
  input  wire logic           pkt_done,
  input  wire logic           carrier_sense,
  input  wire logic [6:0]     signal_quality_value,
  input  wire logic [3:0]     gain_control_word,
  input  wire logic [7:0]     signal_strength_level,
  input  wire logic [15:0]    received_length,
  input  wire logic [23:0]    checksum,
  input  wire logic [31:0]    control,
  input  wire logic [7:0]     source_address_byte,
  input  wire logic [7:0]     destination_address_byte,
  // Cipher engine result
  input  wire logic           cipher_done,
  input  wire logic [127:0]   cipher_result,
  // Calibrator results
  input  wire logic           cal_done,
  input  wire logic [3:0]     oscillator_cal_word_a,
  input  wire logic [4:0]     oscillator_cal_word_b,
  input  wire logic [6:0]     synth_cal_word,
  // Queue fill counts
  input  wire logic [6:0]     tx_queue_count,
  input  wire logic [6:0]     rx_queue_count,
  // Events and pin output
  input  wire logic [31:0]    event_in,
  output logic                irq_out
);
  import rps_pkg::*;

  rps_state_s st_q;
  rps_state_s st_d;

  logic [3:0][7:0] ev_pending;
  logic [3:0]      ev_clear;
  logic [31:0]     ev_all;

  // ==========================================================
  // Event status bytes
  // Byte i holds event bits 8i+7:8i and sits at the last event offset minus i.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_event
      assign ev_clear[gi] = reg_rd &&
                            (reg_addr == (`RPS_EVENT_BYTE0 - 8'(gi)));   // see [RULE_16]
      rps_event_byte u_event (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .set_bits   (event_in[gi*8 +: 8]),
        .read_clear (ev_clear[gi]),
        .pending    (ev_pending[gi])
      );
    end
  endgenerate

  assign ev_all = {ev_pending[3], ev_pending[2], ev_pending[1], ev_pending[0]};

  // ==========================================================
  // Read data selection
  // Pure function of the address and the stored state, so a read has no side
  // effect here; the clearing of event bytes happens in the event instances.
  function automatic logic [7:0] read_value(
    input logic [7:0]  addr,
    input rps_state_s  s,
    input logic [31:0] ev
  );
    logic [7:0] v;
    logic [7:0] idx;
    logic [3:0] byte_sel;
    v        = `RPS_BYTE_RESET;
    idx      = addr - `RPS_CIPHER_FIRST;
    byte_sel = 4'hf - idx[3:0];
    unique case (addr)
      `RPS_MASK_BYTE3: begin
        v = s.event_mask[31:24];
      end
      `RPS_MASK_BYTE2: begin
        v = s.event_mask[23:16];
      end
      `RPS_MASK_BYTE1: begin
        v = s.event_mask[15:8];
      end
      `RPS_MASK_BYTE0: begin
        v = s.event_mask[7:0];
      end
      `RPS_LQ_SENSE_SIGNAL: begin
        v = {s.carrier_sense, s.signal_quality_value};                  // see [RULE_02]
      end
      `RPS_LQ_GAIN: begin
        v = {4'h0, s.gain_control_word};                                // see [RULE_03]
      end
      `RPS_RX_STRENGTH: begin
        v = s.signal_strength_level;                                    // see [RULE_04]
      end
      `RPS_RX_LEN_HIGH: begin
        v = s.received_length[15:`RPS_LEN_HIGH_LSB];                    // see [RULE_01]
      end
      `RPS_RX_LEN_LOW: begin
        v = s.received_length[`RPS_LEN_HIGH_LSB-1:0];                   // see [RULE_01]
      end
      `RPS_RX_CKSUM_BYTE2: begin
        v = s.checksum[23:16];                                          // see [RULE_05]
      end
      `RPS_RX_CKSUM_BYTE1: begin
        v = s.checksum[15:8];                                           // see [RULE_05]
      end
      `RPS_RX_CKSUM_BYTE0: begin
        v = s.checksum[7:0];                                            // see [RULE_05]
      end
      `RPS_RX_CTRL_BYTE0: begin
        v = s.control[7:0];                                             // see [RULE_06]
      end
      `RPS_RX_CTRL_BYTE1: begin
        v = s.control[15:8];                                            // see [RULE_06]
      end
      `RPS_RX_CTRL_BYTE2: begin
        v = s.control[23:16];                                           // see [RULE_06]
      end
      `RPS_RX_CTRL_BYTE3: begin
        v = s.control[31:24];                                           // see [RULE_06]
      end
      `RPS_RX_SRC_ADDR: begin
        v = s.source_address_byte;                                      // see [RULE_07]
      end
      `RPS_RX_DST_ADDR: begin
        v = s.destination_address_byte;                                 // see [RULE_08]
      end
      `RPS_CAL_HIGH: begin
        v = {s.oscillator_cal_word_a, s.oscillator_cal_word_b[4:1]};    // see [RULE_10] [RULE_11]
      end
      `RPS_CAL_LOW: begin
        v = {s.oscillator_cal_word_b[0], s.synth_cal_word};             // see [RULE_11] [RULE_12]
      end
      `RPS_TX_QUEUE_FILL: begin
        v = {1'b0, s.tx_queue_count};                                   // see [RULE_13]
      end
      `RPS_RX_QUEUE_FILL: begin
        v = {1'b0, s.rx_queue_count};                                   // see [RULE_14]
      end
      `RPS_PART_ID: begin
        v = PART_ID_VALUE;
      end
      `RPS_SILICON_REV: begin
        v = REVISION_VALUE;
      end
      `RPS_EVENT_BYTE3: begin
        v = ev[31:24];                                                  // see [RULE_15]
      end
      `RPS_EVENT_BYTE2: begin
        v = ev[23:16];                                                  // see [RULE_15]
      end
      `RPS_EVENT_BYTE1: begin
        v = ev[15:8];                                                   // see [RULE_15]
      end
      `RPS_EVENT_BYTE0: begin
        v = ev[7:0];                                                    // see [RULE_15]
      end
      default: begin
        // Cipher bytes run downward from byte 15; anything else reads zero
        if (addr >= `RPS_CIPHER_FIRST && addr <= `RPS_CIPHER_LAST) begin
          v = s.cipher_result[byte_sel*8 +: 8];                         // see [RULE_09]
        end else begin
          v = `RPS_BYTE_RESET;
        end
      end
    endcase
    return v;
  endfunction : read_value

  // ==========================================================
  // Queue count clamp
  // The queues never hold more than 96 bytes; a larger input is treated as a
  // glitch of the counter and shown as full rather than as a wrapped value.
  function automatic logic [6:0] clamp_count(input logic [6:0] c);
    logic [6:0] r;
    r = c;
    if (c > `RPS_QUEUE_MAX) begin
      r = `RPS_QUEUE_MAX;
    end
    return r;
  endfunction : clamp_count

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;

    // Carrier sense is live, the other packet fields are held per packet
    st_d.carrier_sense = carrier_sense;                                 // see [RULE_02]

    if (pkt_done) begin
      st_d.signal_quality_value     = signal_quality_value;             // see [RULE_02]
      st_d.gain_control_word        = gain_control_word;                // see [RULE_03]
      st_d.signal_strength_level    = signal_strength_level;            // see [RULE_04]
      st_d.received_length          = received_length;                  // see [RULE_01]
      st_d.checksum                 = checksum;                         // see [RULE_05]
      st_d.control                  = control;                          // see [RULE_06]
      st_d.source_address_byte      = source_address_byte;              // see [RULE_07]
      st_d.destination_address_byte = destination_address_byte;         // see [RULE_08]
    end

    if (cipher_done) begin
      st_d.cipher_result = cipher_result;                               // see [RULE_09]
    end

    if (cal_done) begin
      st_d.oscillator_cal_word_a = oscillator_cal_word_a;               // see [RULE_10]
      st_d.oscillator_cal_word_b = oscillator_cal_word_b;               // see [RULE_11]
      st_d.synth_cal_word        = synth_cal_word;                      // see [RULE_12]
    end

    st_d.tx_queue_count = clamp_count(tx_queue_count);                  // see [RULE_13]
    st_d.rx_queue_count = clamp_count(rx_queue_count);                  // see [RULE_14]

    // Mask writes; every other offset is read only and ignores writes
    if (reg_wr) begin
      unique case (reg_addr)
        `RPS_MASK_BYTE3: begin
          st_d.event_mask[31:24] = reg_wdata;                           // see [RULE_17]
        end
        `RPS_MASK_BYTE2: begin
          st_d.event_mask[23:16] = reg_wdata;                           // see [RULE_17]
        end
        `RPS_MASK_BYTE1: begin
          st_d.event_mask[15:8] = reg_wdata;                            // see [RULE_17]
        end
        `RPS_MASK_BYTE0: begin
          st_d.event_mask[7:0] = reg_wdata;                             // see [RULE_17]
        end
        default: begin
          st_d.event_mask = st_q.event_mask;
        end
      endcase
    end

    // Read data is held until the next read so a slow reader can take it late
    st_d.rvalid = reg_rd;
    if (reg_rd) begin
      st_d.rdata = read_value(reg_addr, st_q, ev_all);
    end

    // Pin level follows pending events through the mask, one cycle later
    st_d.irq = |(ev_all & st_q.event_mask);                             // see [RULE_17]
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.event_mask <= `RPS_MASK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata  = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign irq_out    = st_q.irq;

endmodule : rps_status_bank

// *** rps_properties.sv ***
`timescale 1ns/10ps
module rps_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        pkt_done,
  input wire logic [6:0]  signal_quality_value,
  input wire logic [3:0]  gain_control_word,
  input wire logic [7:0]  signal_strength_level,
  input wire logic [15:0] received_length,
  input wire logic [23:0] checksum,
  input wire logic [31:0] control,
  input wire logic [31:0] event_in
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========
  // Steps
  // The read must follow the capture directly, or a later capture could mask a stale byte
  sequence cap_rd(logic [7:0] a);
    pkt_done ##1 (reg_rd && reg_addr == a && !pkt_done);
  endsequence
  sequence ev_rd;
    reg_rd && reg_addr == 8'hfd && event_in == 32'h0000_0000;
  endsequence

  // ==========
  // Properties
  quality_byte_a: assert property (
    cap_rd(8'hc6) |=> reg_rdata[6:0] == $past(signal_quality_value, 2))
    else $error("quality byte wrong");
  gain_byte_a: assert property (
    cap_rd(8'hc7) |=> reg_rdata == {4'h0, $past(gain_control_word, 2)})
    else $error("gain byte wrong");
  strength_byte_a: assert property (
    cap_rd(8'hc8) |=> reg_rdata == $past(signal_strength_level, 2))
    else $error("strength byte wrong");
  length_high_a: assert property (
    cap_rd(8'hc9) |=> reg_rdata == $past(received_length[15:8], 2))
    else $error("length high byte wrong");
  length_low_a: assert property (
    cap_rd(8'hca) |=> reg_rdata == $past(received_length[7:0], 2))
    else $error("length low byte wrong");
  checksum_top_a: assert property (
    cap_rd(8'hcb) |=> reg_rdata == $past(checksum[23:16], 2))
    else $error("checksum byte wrong");
  control_first_a: assert property (
    cap_rd(8'hce) |=> reg_rdata == $past(control[7:0], 2))
    else $error("control byte wrong");
  queue_range_a: assert property (
    reg_rd && (reg_addr == 8'he6 || reg_addr == 8'he7)
    |=> !reg_rdata[7] && reg_rdata[6:0] <= 7'h60) else $error("queue count out of range");
  read_clears_a: assert property (
    ev_rd ##1 (event_in == 32'h0000_0000) [*2] ##1 ev_rd |=> reg_rdata == 8'h00)
    else $error("event byte not cleared");
endmodule : rps_properties

bind rps_status_bank rps_properties u_props (
  .mclk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .pkt_done, .signal_quality_value,
  .gain_control_word, .signal_strength_level, .received_length, .checksum, .control,
  .event_in
);

// *** tb_rx_packet_status_bank.sv ***
`timescale 1ns/10ps
module tb_rx_packet_status_bank;
  import rps_pkg::*;
  // ==========
  // Signals
  localparam logic [7:0] ID_V  = 8'h3c;  // Arbitrary value
  localparam logic [7:0] REV_V = 8'h21;  // Arbitrary value
  logic         mclk = 1'b0, rst_n = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, reg_rvalid, irq_out;
  logic         pkt_done = 1'b0, cipher_done = 1'b0, cal_done = 1'b0, carrier_sense = 1'b0;
  logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, signal_strength_level = '0;
  logic [7:0]   source_address_byte = '0, destination_address_byte = '0;
  logic [6:0]   signal_quality_value = '0, synth_cal_word = '0;
  logic [6:0]   tx_queue_count = '0, rx_queue_count = '0;
  logic [3:0]   gain_control_word = '0, oscillator_cal_word_a = '0;
  logic [4:0]   oscillator_cal_word_b = '0;
  logic [15:0]  received_length = '0;
  logic [23:0]  checksum = '0;
  logic [31:0]  control = '0, event_in = '0, mask, ev;
  logic [127:0] cipher_result = '0;
  logic [319:0] rnd;
  rps_state_s   st, nz;
  int           n_fail = 0, checks_done = 0, cycles = 0;
  logic [7:0]   firsts [7] = '{8'hc6, 8'hc7, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hce};

  rps_status_bank #(.PART_ID_VALUE(ID_V), .REVISION_VALUE(REV_V)) uut (
    .mclk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .pkt_done, .carrier_sense, .signal_quality_value, .gain_control_word,
    .signal_strength_level, .received_length, .checksum, .control, .source_address_byte,
    .destination_address_byte, .cipher_done, .cipher_result, .cal_done,
    .oscillator_cal_word_a, .oscillator_cal_word_b, .synth_cal_word, .tx_queue_count,
    .rx_queue_count, .event_in, .irq_out
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Ceiling is about three and a half times the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========
  // Helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("read strobe high", {7'h00, reg_rvalid}, 8'h01);
    @(posedge mclk);
    #1;
    chk("read strobe low", {7'h00, reg_rvalid}, 8'h00);
    v = reg_rdata;
  endtask : rd

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic drive(rps_state_s s);
    carrier_sense            <= s.carrier_sense;
    signal_quality_value     <= s.signal_quality_value;
    gain_control_word        <= s.gain_control_word;
    signal_strength_level    <= s.signal_strength_level;
    received_length          <= s.received_length;
    checksum                 <= s.checksum;
    control                  <= s.control;
    source_address_byte      <= s.source_address_byte;
    destination_address_byte <= s.destination_address_byte;
    cipher_result            <= s.cipher_result;
    oscillator_cal_word_a    <= s.oscillator_cal_word_a;
    oscillator_cal_word_b    <= s.oscillator_cal_word_b;
    synth_cal_word           <= s.synth_cal_word;
    tx_queue_count           <= s.tx_queue_count;
    rx_queue_count           <= s.rx_queue_count;
  endtask : drive

  function automatic logic [6:0] clamp(logic [6:0] c);
    return (c > 7'h60) ? 7'h60 : c;
  endfunction : clamp

  function automatic logic [7:0] exp_byte(rps_state_s s, logic [7:0] a);
    case (a) inside
      8'hc6:         return {s.carrier_sense, s.signal_quality_value};
      8'hc7:         return {4'h0, s.gain_control_word};
      8'hc8:         return s.signal_strength_level;
      8'hc9:         return s.received_length[15:8];
      8'hca:         return s.received_length[7:0];
      [8'hcb:8'hcd]: return s.checksum[8*(8'hcd-a) +: 8];
      [8'hce:8'hd1]: return s.control[8*(a-8'hce) +: 8];
      8'hd2:         return s.source_address_byte;
      8'hd3:         return s.destination_address_byte;
      [8'hd4:8'he3]: return s.cipher_result[8*(8'he3-a) +: 8];
      8'he4:         return {s.oscillator_cal_word_a, s.oscillator_cal_word_b[4:1]};
      8'he5:         return {s.oscillator_cal_word_b[0], s.synth_cal_word};
      8'he6:         return {1'b0, clamp(s.tx_queue_count)};
      8'he7:         return {1'b0, clamp(s.rx_queue_count)};
      8'hf0:         return ID_V;
      8'hf1:         return REV_V;
      default:       return 8'h00;
    endcase
  endfunction : exp_byte

  // Write to a read-only byte first; it must leave the bank unchanged
  task automatic check_all(rps_state_s s);
    wr(8'hc8, ~exp_byte(s, 8'hc8));
    for (int a = 32'hc6; a <= 32'hf1; a++) begin
      rd(8'(a), d);
      chk($sformatf("byte %h", a), d, exp_byte(s, 8'(a))); // to
    end
  endtask : check_all

  // ==========
  // Tests
  initial begin
    void'($urandom(32'h6eb8));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    st = '0;
    check_all(st);
    for (int j = 0; j < 4; j++) begin
      rd(8'h90 + 8'(j), d);
      chk("mask reset", d, 8'h00);
      rd(8'hfa + 8'(j), d);
      chk("event reset", d, 8'h00);
    end
    $display("test reset_values done");
    for (int i = 0; i < 20; i++) begin
      for (int k = 0; k < 10; k++) rnd[32*k +: 32] = $urandom;
      st = rnd[$bits(rps_state_s)-1:0];
      if (i == 0) begin
        st.tx_queue_count  = 7'h60;
        st.rx_queue_count  = 7'h61;
        st.received_length = 16'hffff;
      end
      if (i == 1) begin
        st.tx_queue_count  = 7'h7f;
        st.rx_queue_count  = 7'h00;
        st.received_length = 16'h0100;
      end
      // Live inputs keep their values; captured ones are scrambled after the pulse
      nz = ~st;
      nz.carrier_sense  = st.carrier_sense;
      nz.tx_queue_count = st.tx_queue_count;
      nz.rx_queue_count = st.rx_queue_count;
      @(posedge mclk);
      drive(st);
      pkt_done    <= 1'b1;
      cipher_done <= 1'b1;
      cal_done    <= 1'b1;
      @(posedge mclk);
      drive(nz);
      pkt_done    <= 1'b0;
      cipher_done <= 1'b0;
      cal_done    <= 1'b0;
      reg_rd      <= 1'b1;
      reg_addr    <= firsts[i % 7];
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      #1;
      chk("first read", reg_rdata, exp_byte(st, firsts[i % 7])); // to
      check_all(st);
    end
    $display("test capture done");
    // Reset in mid-run must drop every captured field back to zero
    @(posedge mclk);
    drive('0);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    check_all('0);
    $display("test mid_reset done");
    for (int i = 0; i < 8; i++) begin
      mask = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : $urandom;
      ev   = $urandom | 32'h0000_0001;
      for (int j = 0; j < 4; j++) wr(8'h90 + 8'(j), mask[8*(3-j) +: 8]);
      for (int j = 0; j < 4; j++) begin
        rd(8'h90 + 8'(j), d);
        chk("mask byte", d, mask[8*(3-j) +: 8]);
      end
      @(posedge mclk);
      event_in <= ev;
      @(posedge mclk);
      event_in <= '0;
      @(posedge mclk);
      #1;
      chk("irq raised", {7'h00, irq_out}, {7'h00, |(ev & mask)});
      for (int j = 0; j < 4; j++) begin
        rd(8'hfa + 8'(j), d);
        chk("event byte", d, ev[8*(3-j) +: 8]);
      end
      rd(8'hfd, d);
      chk("event cleared", d, 8'h00);
      chk("irq cleared", {7'h00, irq_out}, 8'h00);
    end
    $display("test events done");
    print_verdict();
  end
endmodule : tb_rx_packet_status_bank
